// file: wii_core.sv
// Wake input logic with filtered and cyclic sensing and pulsed interrupt
`timescale 1ns/1ps
module wii_core #(
    parameter int IRQ_PULSE_CYC = wii_pkg::IRQ_PULSE_CYC,
    parameter int IRQ_GAP_CYC   = wii_pkg::IRQ_GAP_CYC
) (
    input  wire logic                       CORE_CLK,
    input  wire logic                       RST_N,
    input  wire wii_pkg::wii_mode_t         MODE,
    input  wire logic                       HV_WAKE_PIN,
    input  wire logic                       FAIL_MULTIPURPOSE_PIN,
    input  wire logic                       GPIO_IS_WAKE_INPUT,
    input  wire logic                       WAKE_PIN_ENABLE,
    input  wire logic                       CYCLIC_SENSE_SEL,
    input  wire logic                       GPIO_HIGH_SIDE_SWITCH,
    input  wire logic [1:0]                 WAKE_PULL_CONFIG,
    input  wire logic                       HV_MEASURE_ENABLE,
    input  wire logic                       IRQ_CLASS_GLOBAL,
    input  wire logic                       CAN_WAKE_EVT,
    input  wire logic                       CAN_WAKE_EN,
    input  wire logic                       TIMER_WAKE_EVT,
    input  wire logic                       TIMER_WAKE_EN,
    input  wire logic [wii_pkg::FAIL_W-1:0] FAIL_EVT,
    input  wire logic [wii_pkg::EXC_W-1:0]  EXC_EVT,
    input  wire logic                       CLR_WAKE_FIRST,
    input  wire logic                       CLR_WAKE_SECOND,
    input  wire logic                       CLR_FAIL_STATUS,
    input  wire logic                       CLR_EXC_STATUS,
    input  wire logic                       SLEEP_REQ,
    output logic                            IRQ_OUT_N,
    output logic [wii_pkg::WS1_W-1:0]       WAKE_STATUS_FIRST,
    output logic                            WAKE_STATUS_SECOND,
    output logic [wii_pkg::LVL_W-1:0]       WAKE_LEVEL_STATUS,
    output logic [wii_pkg::FAIL_W-1:0]      FAIL_STATUS,
    output logic [wii_pkg::EXC_W-1:0]       EXC_STATUS,
    output logic                            PULL_UP_ON,
    output logic                            PULL_DOWN_ON,
    output logic                            MEAS_ROUTE_ON,
    output logic                            WAKE_UP_REQ,
    output logic                            SLEEP_GRANT,
    output logic                            SPI_FAIL_SET,
    output logic                            RESTART_REQ
);
    localparam int W1 = wii_pkg::WS1_W;
    localparam int FW = wii_pkg::FAIL_W;
    localparam int EW = wii_pkg::EXC_W;

    typedef struct packed {
        wii_pkg::wii_mode_t  mode_prev;
        logic                hs_prev;
        logic                samp;
        logic                samp_valid;
        logic                cyc_evt;
        logic [W1-1:0]       pend1;
        logic                pend2;
        logic [FW-1:0]       pendf;
        logic                stop_entry;
        logic [W1-1:0]       ws1;
        logic                ws2;
        logic [FW-1:0]       fail;
        logic [EW-1:0]       exc;
        logic [wii_pkg::LVL_W-1:0] lvl;
        logic                pull_up;
        logic                pull_dn;
        logic                meas;
        logic                wake_up;
        logic                sleep_ok;
        logic                spi_fail;
        logic                restart;
    } wii_core_t;

    wii_core_t s_q;
    wii_core_t s_d;

    wii_irq_if irq ();

    logic hv_level;
    logic hv_evt;
    logic gp_level;
    logic gp_evt;
    logic mode_ok;
    logic hv_wake;
    logic gp_wake;
    logic [W1-1:0] new1;
    logic          pub;
    logic          sole_pin;

    // static filter on the wake pin
    wii_filter #(
        .CYC   (wii_pkg::WAKE_FILTER_CYC)
    ) u_hv_filter (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .pin   (HV_WAKE_PIN),
        .arm   (!HV_MEASURE_ENABLE && !CYCLIC_SENSE_SEL),
        .level (hv_level),
        .evt   (hv_evt)
    );

    // same static filter on the multipurpose pin
    wii_filter #(
        .CYC   (wii_pkg::WAKE_FILTER_CYC)
    ) u_gp_filter (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .pin   (FAIL_MULTIPURPOSE_PIN),
        .arm   (GPIO_IS_WAKE_INPUT && !HV_MEASURE_ENABLE),
        .level (gp_level),
        .evt   (gp_evt)
    );

    wii_pulse #(
        .PULSE_CYC (IRQ_PULSE_CYC),
        .GAP_CYC   (IRQ_GAP_CYC)
    ) u_pulse (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .irq   (irq.gen)
    );

    // either edge counts; measurement gates the internal wake
    always_comb
    begin
        mode_ok  = wii_pkg::irq_mode_ok(MODE);
        hv_wake  = !HV_MEASURE_ENABLE && WAKE_PIN_ENABLE && (CYCLIC_SENSE_SEL ? s_q.cyc_evt : hv_evt);
        gp_wake  = !HV_MEASURE_ENABLE && GPIO_IS_WAKE_INPUT && gp_evt;
        // only sources enabled for wake are recorded
        new1     = '0;
        new1[wii_pkg::WS1_CAN]   = CAN_WAKE_EN && CAN_WAKE_EVT;
        new1[wii_pkg::WS1_PIN]   = hv_wake;
        new1[wii_pkg::WS1_TIMER] = TIMER_WAKE_EN && TIMER_WAKE_EVT;
        sole_pin = WAKE_PIN_ENABLE && !CAN_WAKE_EN && !TIMER_WAKE_EN && !GPIO_IS_WAKE_INPUT;
        // pending events are published as the pulse starts, and at once outside normal and stop
        pub      = irq.start || !mode_ok;
    end

    // wake events interrupt; failures only in global class
    // restart and fail-safe flags have no path to the request
    // requests and pulses are blocked outside normal and stop
    assign irq.req   = mode_ok && ((|s_q.pend1) || s_q.pend2 || (IRQ_CLASS_GLOBAL && (|s_q.pendf)) || s_q.stop_entry);
    assign irq.abort = !mode_ok;

    always_comb
    begin
        s_d           = s_q;
        s_d.mode_prev = MODE;
        s_d.hs_prev   = GPIO_HIGH_SIDE_SWITCH;
        s_d.cyc_evt   = 1'b0;

        // sample only while the high-side switch is on
        if (!CYCLIC_SENSE_SEL || HV_MEASURE_ENABLE)
        begin
            s_d.samp_valid = 1'b0;
        end
        else if (GPIO_HIGH_SIDE_SWITCH)
        begin
            s_d.samp       = HV_WAKE_PIN;
            s_d.samp_valid = 1'b1;
            s_d.cyc_evt    = s_q.samp_valid && (HV_WAKE_PIN != s_q.samp);
        end

        // Pending set wins over the publish that empties it
        s_d.pend1 = (pub ? '0 : s_q.pend1) | new1;
        s_d.pend2 = (pub ? 1'b0 : s_q.pend2) | gp_wake;
        if (IRQ_CLASS_GLOBAL)
            s_d.pendf = (pub ? '0 : s_q.pendf) | FAIL_EVT;
        else
            s_d.pendf = '0;

        // sticky first wake status; cleared only by the host
        s_d.ws1 = (s_q.ws1 & ~{W1{CLR_WAKE_FIRST}}) | (pub ? s_q.pend1 : '0);
        // multipurpose pin wake lands in second wake status
        s_d.ws2 = (s_q.ws2 && !CLR_WAKE_SECOND) || (pub && s_q.pend2);
        // Without global class failures latch at once but never interrupt; a pending one is kept, not lost
        s_d.fail = (s_q.fail & ~{FW{CLR_FAIL_STATUS}})
                 | (IRQ_CLASS_GLOBAL ? (pub ? s_q.pendf : '0) : (FAIL_EVT | s_q.pendf));
        // these flags latch only, no interrupt
        s_d.exc = (s_q.exc & ~{EW{CLR_EXC_STATUS}}) | EXC_EVT;

        // stop entry with wake bits left pulses once
        if (MODE == wii_pkg::MODE_STOP && s_q.mode_prev != wii_pkg::MODE_STOP && ((|s_q.ws1) || s_q.ws2))
            s_d.stop_entry = 1'b1;
        else if (irq.start || MODE != wii_pkg::MODE_STOP)
            s_d.stop_entry = 1'b0;

        // live or sampled level; forced to zero when measuring
        if (HV_MEASURE_ENABLE)
            s_d.lvl = '0;
        else
        begin
            s_d.lvl[wii_pkg::LVL_HV]   = CYCLIC_SENSE_SEL ? s_q.samp : hv_level;
            s_d.lvl[wii_pkg::LVL_GPIO] = GPIO_IS_WAKE_INPUT ? gp_level : 1'b0;
        end

        // pull decode; auto follows the detected level
        s_d.pull_up = 1'b0;
        s_d.pull_dn = 1'b0;
        if (!HV_MEASURE_ENABLE)
        begin
            case (WAKE_PULL_CONFIG)
                wii_pkg::PULL_DOWN: s_d.pull_dn = 1'b1;
                wii_pkg::PULL_UP:   s_d.pull_up = 1'b1;
                wii_pkg::PULL_AUTO:
                begin
                    s_d.pull_up = s_q.lvl[wii_pkg::LVL_HV];
                    s_d.pull_dn = !s_q.lvl[wii_pkg::LVL_HV];
                end
                default:            s_d.pull_up = 1'b0;
            endcase
        end

        // measurement routes the pin out and idles the wake pin and multipurpose pin wakes
        s_d.meas = HV_MEASURE_ENABLE;

        // in low power modes a wake event wakes instead of interrupting
        s_d.wake_up = wii_pkg::wake_mode(MODE) && ((|new1) || gp_wake);

        // sleep refused when the gated wake pin is the only source
        s_d.spi_fail = SLEEP_REQ && HV_MEASURE_ENABLE && sole_pin;
        s_d.restart  = SLEEP_REQ && HV_MEASURE_ENABLE && sole_pin;
        s_d.sleep_ok = SLEEP_REQ && !(HV_MEASURE_ENABLE && sole_pin);
    end

    // State register; pull sources reset to none
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
            s_q <= '{mode_prev: wii_pkg::MODE_INIT, default: '0};
        else
            s_q <= s_d;
    end

    // the pulser owns the pin; mode is never touched here
    assign IRQ_OUT_N          = irq.irq_n;
    assign WAKE_STATUS_FIRST  = s_q.ws1;
    assign WAKE_STATUS_SECOND = s_q.ws2;
    assign WAKE_LEVEL_STATUS  = s_q.lvl;
    assign FAIL_STATUS        = s_q.fail;
    assign EXC_STATUS         = s_q.exc;
    assign PULL_UP_ON         = s_q.pull_up;
    assign PULL_DOWN_ON       = s_q.pull_dn;
    assign MEAS_ROUTE_ON      = s_q.meas;
    assign WAKE_UP_REQ        = s_q.wake_up;
    assign SLEEP_GRANT        = s_q.sleep_ok;
    assign SPI_FAIL_SET       = s_q.spi_fail;
    assign RESTART_REQ        = s_q.restart;

    // Helper sequences for the checks
    sequence s_meas3;
        HV_MEASURE_ENABLE [*3];
    endsequence

    sequence s_blocked2;
        !wii_pkg::irq_mode_ok(MODE) ##1 !wii_pkg::irq_mode_ok(MODE);
    endsequence

    // no low output from the second cycle outside normal and stop
    chk_irq_mode_block: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_blocked2 |-> IRQ_OUT_N)
        else $error("interrupt low in a blocked mode");

    // pending wake starts a pulse next cycle
    chk_wake_irq_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (mode_ok && irq.ready && (|s_q.pend1)) |=> !IRQ_OUT_N)
        else $error("pending wake did not pulse the interrupt");

    // class 0 failures alone never request
    chk_class0_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!IRQ_CLASS_GLOBAL && !(|s_q.pend1) && !s_q.pend2 && !s_q.stop_entry) |-> !irq.req)
        else $error("interrupt requested without a wake event");

    // published status holds what was pending at the pulse start
    chk_publish_fall: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        irq.start |=> (s_q.ws1 & $past(s_q.pend1)) == $past(s_q.pend1) && $fell(IRQ_OUT_N))
        else $error("status not updated at interrupt falling edge");

    // measurement keeps level at zero and the pin bit from rising
    chk_meas_freeze: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        s_meas3 |-> s_q.lvl == '0 && !$rose(s_q.ws1[wii_pkg::WS1_PIN]))
        else $error("status moved during measurement");

    // auto pull follows the level seen one cycle before
    chk_pull_auto: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!HV_MEASURE_ENABLE && WAKE_PULL_CONFIG == wii_pkg::PULL_AUTO)
        |=> PULL_UP_ON == $past(s_q.lvl[wii_pkg::LVL_HV]) && PULL_DOWN_ON != PULL_UP_ON)
        else $error("automatic pull does not follow the level");

    // refused sleep raises failure and restart together
    chk_sleep_refuse: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (SLEEP_REQ && HV_MEASURE_ENABLE && sole_pin) |=> SPI_FAIL_SET && RESTART_REQ && !SLEEP_GRANT)
        else $error("sleep not refused during measurement");

    // stop entry with leftover wake bits is remembered
    chk_stop_entry: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (MODE == wii_pkg::MODE_STOP && s_q.mode_prev != wii_pkg::MODE_STOP && (|s_q.ws1))
        |=> s_q.stop_entry || !IRQ_OUT_N)
        else $error("stop entry did not request a pulse");

    // the pin wake status bit drops only on a host clear
    chk_sticky_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $fell(s_q.ws1[wii_pkg::WS1_PIN]) |-> $past(CLR_WAKE_FIRST))
        else $error("wake status dropped without a clear");
endmodule

// file: wii_core_tb.sv
// Self-checking bench of the wake input and interrupt block
`timescale 1ns/1ps
module wii_core_tb;
    localparam int PW = 20;
    logic clk, rst_n, pin, wen, meas, cls, can, can_en, ten, slp, clr;
    logic cyc, hs, gpin, gwk, tmr, ws2;
    logic irq_n, pu, pd, mr, wu, sg, sf, rr;
    logic [1:0] pc, lvl;
    logic [2:0] ws1;
    logic [3:0] fe, fst;
    logic [5:0] exc, est;
    logic [31:0] seed;
    logic [7:0] q[$];
    wii_pkg::wii_mode_t mode;
    int fails, checks_done, n;

    wii_core #(.IRQ_PULSE_CYC(PW), .IRQ_GAP_CYC(PW)) wii_core_i (
        .CORE_CLK(clk), .RST_N(rst_n), .MODE(mode), .HV_WAKE_PIN(pin), .FAIL_MULTIPURPOSE_PIN(gpin),
        .GPIO_IS_WAKE_INPUT(gwk), .WAKE_PIN_ENABLE(wen), .CYCLIC_SENSE_SEL(cyc), .GPIO_HIGH_SIDE_SWITCH(hs),
        .WAKE_PULL_CONFIG(pc), .HV_MEASURE_ENABLE(meas), .IRQ_CLASS_GLOBAL(cls), .CAN_WAKE_EVT(can),
        .CAN_WAKE_EN(can_en), .TIMER_WAKE_EVT(tmr), .TIMER_WAKE_EN(ten), .FAIL_EVT(fe), .EXC_EVT(exc),
        .CLR_WAKE_FIRST(clr), .CLR_WAKE_SECOND(clr), .CLR_FAIL_STATUS(clr), .CLR_EXC_STATUS(clr),
        .SLEEP_REQ(slp), .IRQ_OUT_N(irq_n), .WAKE_STATUS_FIRST(ws1), .WAKE_STATUS_SECOND(ws2),
        .WAKE_LEVEL_STATUS(lvl), .FAIL_STATUS(fst), .EXC_STATUS(est), .PULL_UP_ON(pu), .PULL_DOWN_ON(pd),
        .MEAS_ROUTE_ON(mr), .WAKE_UP_REQ(wu), .SLEEP_GRANT(sg), .SPI_FAIL_SET(sf), .RESTART_REQ(rr)
    );
    wii_host wii_host_i (.clk(clk), .irq_n(irq_n), .clr(clr));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic sreq(input logic [7:0] e);
        slp = 1'b1;
        tick(1);
        // Answer stands for one cycle only
        cmp({5'h0, sf, rr, sg}, e);
        slp = 1'b0;
        tick(1);
    endtask
    task automatic complete_run;
        $display("fails=%0d checks_done=%0d", fails, checks_done);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Clock and watchdog; an unexpected pulse pops a note that never matches
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        #200000;
        fails++;
        complete_run();
    end
    always @(negedge irq_n)
    begin
        #1;
        cmp({ws2, ws1, fst}, q.size() ? q.pop_front() : 8'hFF);
        n = 0;
        while (irq_n === 1'b0)
        begin
            @(posedge clk) #1;
            n++;
        end
        cmp(8'(n), 8'(PW));
        // Reread once the host clear has landed
        repeat (4) @(negedge clk);
        cmp({ws2, ws1, fst}, 8'h00);
    end

    // Main sequence, inputs change on the falling edge
    initial
    begin
        {rst_n, pin, wen, meas, cls, can, can_en, ten, slp, pc, fe, exc, cyc, hs, gpin, gwk, tmr} = '0;
        mode = wii_pkg::MODE_NORMAL;
        seed = 32'hD89FDC7C;
        tick(10);
        rst_n = 1'b1;
        tick(1);
        cmp({irq_n, ws1, fst}, 8'h80);
        for (int c = 0; c < 4; c++)
        begin
            pc = 2'(c);
            tick(3);
            cmp({6'h0, pu, pd}, {6'h0, c == 2, c[0]});
        end
        cls = 1'b1;
        seed = xs(seed);
        fe = 4'h1 << seed[1:0];
        q.push_back({4'h0, fe});
        tick(1);
        fe = 4'h0;
        // Class stays global until the pulse has started
        tick(1);
        cls = 1'b0;
        can_en = 1'b1;
        tick(60);
        can = 1'b1;
        q.push_back(8'h10);
        tick(1);
        can = 1'b0;
        tick(60);
        wen = 1'b1;
        pin = 1'b1;
        tick(1000);
        pin = 1'b0;
        tick(1100);
        for (int k = 0; k < 2; k++)
        begin
            pin = ~pin;
            q.push_back(8'h20);
            tick(2100);
            cmp({7'h0, pu}, {7'h0, pin});
        end
        meas = 1'b1;
        can_en = 1'b0;
        pin = 1'b1;
        tick(2100);
        cmp({4'h0, mr, pu, pd, lvl[0]}, 8'h08);
        sreq(8'h06);
        ten = 1'b1;
        sreq(8'h01);
        ten = 1'b0;
        pin = 1'b0;
        tick(2100);
        meas = 1'b0;
        can_en = 1'b1;
        mode = wii_pkg::MODE_SLEEP;
        tick(3);
        can = 1'b1;
        tick(1);
        cmp({7'h0, wu}, 8'h01);
        can = 1'b0;
        tick(1);
        tick(60);
        q.push_back(8'h10);
        mode = wii_pkg::MODE_STOP;
        tick(60);
        // Timer, multipurpose pin and cyclic sensing wakes in stop mode
        ten = 1'b1;
        tmr = 1'b1;
        q.push_back(8'h40);
        tick(1);
        {ten, tmr} = 2'h0;
        tick(60);
        gwk = 1'b1;
        tick(3);
        gpin = 1'b1;
        q.push_back(8'h80);
        tick(2100);
        cmp({6'h0, lvl}, 8'h02);
        {gwk, gpin} = 2'h0;
        cyc = 1'b1;
        hs = 1'b1;
        tick(3);
        pin = 1'b1;
        q.push_back(8'h20);
        tick(3);
        {hs, pin} = 2'h0;
        tick(60);
        // Switch off, so the level shows the last sample, not the pin
        cmp({7'h0, lvl[0]}, 8'h01);
        cyc = 1'b0;
        tick(60);
        mode = wii_pkg::MODE_NORMAL;
        cls = 1'b1;
        seed = xs(seed);
        exc = 6'h1 << (seed % 6);
        tick(1);
        exc = 6'h0;
        cls = 1'b0;
        fe = 4'h8;
        tick(1);
        fe = 4'h0;
        tick(40);
        cmp({2'h0, est}, {2'h0, 6'h1 << (seed % 6)});
        cmp({4'h0, fst}, 8'h08);
        cmp(8'(q.size()), 8'h00);
        complete_run();
    end
endmodule

// file: wii_filter.sv
// Edge filter that accepts a level change only after it holds for a set time
`timescale 1ns/1ps
module wii_filter #(
    parameter int CYC = wii_pkg::WAKE_FILTER_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    input  wire logic arm,
    output logic      level,
    output logic      evt
);
    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic          stable;
        logic [CW-1:0] cnt;
        logic          evt;
    } wii_flt_t;

    wii_flt_t s_q;
    wii_flt_t s_d;

    // Count while the pin differs; a cross back restarts the wait
    always_comb
    begin
        s_d     = s_q;
        s_d.evt = 1'b0;
        if (!arm)
        begin
            // Disarmed input tracks silently so arming does not fake an edge
            s_d.stable = pin;
            s_d.cnt    = '0;
        end
        else if (pin != s_q.stable)
        begin
            if (s_q.cnt == CW'(CYC - 1))
            begin
                s_d.stable = pin;
                s_d.cnt    = '0;
                s_d.evt    = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
        end
        else
        begin
            s_d.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level = s_q.stable;
    assign evt   = s_q.evt;

    chk_filter_full_time: assert property (@(posedge clk) disable iff (!rst_n)
        evt |-> $past(s_q.cnt) == CW'(CYC - 1) && $past(pin) != $past(s_q.stable))
        else $error("wake accepted before the filter time ran out");
endmodule

// file: wii_host.sv
// Host model: reads and clears the wake, failure and exception status registers after each pulse
`timescale 1ns/1ps
module wii_host (
    input  wire logic clk,
    input  wire logic irq_n,
    output logic      clr
);
    // Clear lands two cycles after the line is released
    initial
    begin
        clr = 1'b0;
        forever
        begin
            @(posedge irq_n);
            repeat (2) @(negedge clk);
            // read and clear; confirm read follows in the bench
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
        end
    end
endmodule

// file: wii_irq_if.sv
// Request and pulse signals between the block core and its interrupt pulser
`timescale 1ns/1ps
interface wii_irq_if;
    logic req;
    logic abort;
    logic ready;
    logic start;
    logic irq_n;

    modport gen
    (
        input  req,
        input  abort,
        output ready,
        output start,
        output irq_n
    );

    modport user
    (
        output req,
        output abort,
        input  ready,
        input  start,
        input  irq_n
    );
endinterface

// file: wii_pkg.sv
// Shared constants, types and helpers of the wake input and interrupt block
package wii_pkg;

    // Core clock period in picoseconds (125 MHz)
    localparam int CLK_PERIOD_PS   = 8000;

    // Wake filter time in microseconds; a least time, so cycles round up
    localparam int WAKE_FILTER_US  = 16;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Interrupt pulse width and least gap between pulses, in microseconds
    localparam int IRQ_PULSE_US    = 100;
    localparam int IRQ_PULSE_CYC   = (IRQ_PULSE_US * 1000000) / CLK_PERIOD_PS;
    localparam int IRQ_GAP_US      = 100;
    localparam int IRQ_GAP_CYC     = (IRQ_GAP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Pull source select codes
    localparam logic [1:0] PULL_NONE  = 2'h0;
    localparam logic [1:0] PULL_DOWN  = 2'h1;
    localparam logic [1:0] PULL_UP    = 2'h2;
    localparam logic [1:0] PULL_AUTO  = 2'h3;
    localparam logic [1:0] PULL_RESET = PULL_NONE;

    // Bit positions of the first wake status register
    localparam int WS1_CAN   = 0;
    localparam int WS1_PIN   = 1;
    localparam int WS1_TIMER = 2;
    localparam int WS1_W     = 3;

    // Bit positions of the level status register
    localparam int LVL_HV    = 0;
    localparam int LVL_GPIO  = 1;
    localparam int LVL_W     = 2;

    // Widths of interrupting failure flags and of restart or fail-safe flags
    localparam int FAIL_W    = 4;
    localparam int EXC_W     = 6;

    // Operating modes of the device
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } wii_mode_t;

    // Interrupt pulses are allowed only in normal and stop mode
    function automatic logic irq_mode_ok(input wii_mode_t m);
        irq_mode_ok = (m == MODE_NORMAL) || (m == MODE_STOP);
    endfunction

    // Low power modes in which a wake event wakes the device instead
    function automatic logic wake_mode(input wii_mode_t m);
        wake_mode = (m == MODE_SLEEP) || (m == MODE_FAILSAFE);
    endfunction

endpackage

// file: wii_pulse.sv
// Interrupt pulser: fixed low time cut short only by an abort, then a least high time before the next
`timescale 1ns/1ps
module wii_pulse #(
    parameter int PULSE_CYC = wii_pkg::IRQ_PULSE_CYC,
    parameter int GAP_CYC   = wii_pkg::IRQ_GAP_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    wii_irq_if.gen    irq
);
    localparam int CW = $clog2((PULSE_CYC > GAP_CYC ? PULSE_CYC : GAP_CYC) + 1);

    typedef enum logic [1:0] {
        P_IDLE,
        P_LOW,
        P_GAP
    } wii_pst_t;

    typedef struct packed {
        wii_pst_t      st;
        logic [CW-1:0] cnt;
        logic          irq_n;
    } wii_pls_t;

    wii_pls_t s_q;
    wii_pls_t s_d;

    // Ready only when idle, so the gap can never be cut short
    assign irq.ready = (s_q.st == P_IDLE) && !irq.abort;
    assign irq.start = irq.req && irq.ready;
    assign irq.irq_n = s_q.irq_n;

    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            P_IDLE:
            begin
                if (irq.start)
                begin
                    s_d.st    = P_LOW;
                    s_d.cnt   = '0;
                    s_d.irq_n = 1'b0;
                end
            end
            P_LOW:
            begin
                // Abort releases at once; the gap still follows
                if (irq.abort || s_q.cnt == CW'(PULSE_CYC - 1))
                begin
                    s_d.st    = P_GAP;
                    s_d.cnt   = '0;
                    s_d.irq_n = 1'b1;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + CW'(1);
                end
            end
            P_GAP:
            begin
                if (s_q.cnt == CW'(GAP_CYC - 1))
                    s_d.st = P_IDLE;
                else
                    s_d.cnt = s_q.cnt + CW'(1);
            end
            default:
            begin
                s_d.st    = P_IDLE;
                s_d.irq_n = 1'b1;
            end
        endcase
    end

    // State register; the output rests high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_q <= '{st: P_IDLE, cnt: '0, irq_n: 1'b1};
        else
            s_q <= s_d;
    end

    chk_pulse_width: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(irq.irq_n) |-> $past(s_q.cnt) == CW'(PULSE_CYC - 1) || $past(irq.abort))
        else $error("interrupt released at the wrong time");

    chk_gap_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == P_GAP && s_q.cnt != CW'(GAP_CYC - 1)) |=> s_q.st == P_GAP && irq.irq_n)
        else $error("interrupt gap cut short");
endmodule
